// [core/drq_arb_if.sv]
// channel requests and winner between core and priority picker
`timescale 1ns/1ps
interface drq_arb_if;
	logic [3:0] pend;
	logic rot_en;
	logic done;
	logic [1:0] done_ch;
	logic hit;
	logic [1:0] win;
	logic [1:0] top;
	modport req(output pend, rot_en, done, done_ch, input hit, win, top);
	modport arb(input pend, rot_en, done, done_ch, output hit, win, top);
endinterface : drq_arb_if

// [core/drq_core.sv]
// request sensing, arbitration and bus hand-over for four channels
`timescale 1ns/1ps
module drq_core
	import drq_pkg::*;
#(
	parameter int UNIT_CYC = UNIT_CYC_DEF
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	input wire logic [NCH-1:0] ext_xfer_request_n,
	input wire logic terminal_count_n,
	input wire logic [NPER-1:0] periph_evt,
	input wire logic refresh_req,
	input wire logic hold_req,
	output drq_own_t bus_owner,
	output logic [1:0] xfer_ch,
	output logic unit_pulse,
	output logic xfer_done
);
	drq_arb_if ai ();
	drq_st_t state_r;
	drq_own_t own_r;
	logic rot_r;
	logic [3:0] perm_r;
	logic [3:0] flag_r;
	logic [3:0] set_v;
	logic [3:0] lvl;
	logic [15:0] ctrl_r [NCH];
	logic [15:0] mode_r [NCH];
	logic [15:0] cnt_r [NCH];
	logic [15:0] rld_r [NCH];
	logic [7:0] blk_r [NCH];
	logic [1:0] act_r;
	logic [7:0] cyc_r;
	logic [DW-1:0] rdata_r;
	logic unit_r;
	logic done_r;
	logic [4:0] pin_low;
	logic [4:0] pin_fall;
	logic term_low;
	logic wr_gxc;
	logic [5:0] blk_sel;
	logic [1:0] ridx;
	logic unit_end;
	logic steal;
	logic chain;
	logic last;
	logic force_end;
	logic done;
	logic yield_now;
	logic idle_go;
	logic cs_next;
	logic accept;

	drq_pin_sync #(
		.W(5)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pin_n({terminal_count_n, ext_xfer_request_n}),
		.low(pin_low),
		.fall(pin_fall)
	);

	drq_prio u_prio (
		.clock(clock),
		.sys_rst(sys_rst),
		.ai(ai.arb)
	);

	// decode and transfer conditions
	assign term_low = pin_low[4];
	assign blk_sel = reg_addr[7:2];
	assign ridx = reg_addr[1:0];
	assign wr_gxc = reg_wr && reg_addr == A_GXC;
	assign unit_end = state_r == ST_XFER && cyc_r == 8'(UNIT_CYC - 1);
	assign steal = mode_r[act_r][B_STEAL];
	assign chain = mode_r[act_r][B_CHAIN];
	assign last = cnt_r[act_r] == 16'h0001 && (!chain || blk_r[act_r] == RST_BLK);
	assign force_end = state_r != ST_IDLE && (!perm_r[act_r] || term_low);
	assign done = unit_end && last && !force_end;
	assign yield_now = refresh_req || hold_req;
	assign idle_go = state_r == ST_IDLE && !yield_now && ai.hit;
	assign cs_next = unit_end && !force_end && !done && steal && !yield_now && ai.hit;
	assign accept = idle_go || cs_next;

	// priority picker hookup
	assign ai.pend = perm_r & flag_r & ~(done ? 4'h1 << act_r : 4'h0);
	assign ai.rot_en = rot_r;
	assign ai.done = done;
	assign ai.done_ch = act_r;

	// global control: priority mode and permits
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rot_r <= RST_GXC[B_ROT];
			perm_r <= RST_GXC[B_PERM+3:B_PERM];
		end else begin
			if (wr_gxc) begin
				rot_r <= reg_wdata[B_ROT];
				perm_r <= reg_wdata[B_PERM+3:B_PERM];
			end
			if (done) begin
				perm_r[act_r] <= 1'b0;
			end
		end
	end

	// per-channel control and mode registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				ctrl_r[i] <= RST_CTRL;
				mode_r[i] <= RST_MODE;
			end
		end else if (reg_wr) begin
			if (blk_sel == A_CTRL[7:2]) begin
				ctrl_r[ridx] <= reg_wdata;
			end
			if (blk_sel == A_MODE[7:2]) begin
				mode_r[ridx] <= reg_wdata;
			end
		end
	end

	// transfer and block counters
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				cnt_r[i] <= RST_CNT;
				rld_r[i] <= RST_CNT;
				blk_r[i] <= RST_BLK;
			end
		end else begin
			if (reg_wr && blk_sel == A_CNT[7:2]) begin
				cnt_r[ridx] <= reg_wdata;
				rld_r[ridx] <= reg_wdata;
			end
			if (reg_wr && blk_sel == A_BLK[7:2]) begin
				blk_r[ridx] <= reg_wdata[7:0];
			end
			if (unit_end && !force_end && cnt_r[act_r] != RST_CNT) begin
				if (cnt_r[act_r] == 16'h0001 && chain && blk_r[act_r] != RST_BLK) begin
					cnt_r[act_r] <= rld_r[act_r];
					blk_r[act_r] <= blk_r[act_r] - 8'h01;
				end else begin
					cnt_r[act_r] <= cnt_r[act_r] - 16'h0001;
				end
			end
		end
	end

	// request flags, one per channel
	for (genvar g = 0; g < NCH; g++) begin : g_flag
		logic [3:0] src;
		logic clr;
		assign src = ctrl_r[g][3:0];
		assign lvl[g] = ctrl_r[g][B_LVL] && src == SRC_EXT;
		always_comb begin
			set_v[g] = 1'b0;
			if (src == SRC_EXT) begin
				set_v[g] = pin_fall[g];
			end else if (src == SRC_SW) begin
				set_v[g] = wr_gxc && reg_wdata[B_SWRQ + g];
			end else if (src >= SRC_PER) begin
				set_v[g] = periph_evt[4'(src - SRC_PER)];
			end
		end
		assign clr = (reg_wr && blk_sel == A_CTRL[7:2] && ridx == 2'(g) && !reg_wdata[B_FLAG])
			|| (wr_gxc && !reg_wdata[B_PERM + g])
			|| (state_r != ST_IDLE && act_r == 2'(g) && (done || term_low))
			|| (accept && ai.win == 2'(g) && mode_r[g][B_STEAL]);
		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				flag_r[g] <= 1'b0;
			end else if (lvl[g]) begin
				flag_r[g] <= pin_low[g];
			end else begin
				flag_r[g] <= set_v[g] || (flag_r[g] && !clr);
			end
		end
	end

	// bus ownership state machine
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			own_r <= OWN_CPU;
			act_r <= 2'b00;
			cyc_r <= 8'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					cyc_r <= 8'h00;
					if (refresh_req) begin
						own_r <= OWN_REF;
					end else if (hold_req) begin
						own_r <= OWN_HOLD;
					end else if (idle_go) begin
						own_r <= OWN_DMA;
						act_r <= ai.win;
						state_r <= ST_XFER;
					end else begin
						own_r <= OWN_CPU;
					end
				end
				ST_XFER: begin
					if (force_end) begin
						state_r <= ST_IDLE;
						own_r <= OWN_CPU;
					end else if (!unit_end) begin
						cyc_r <= cyc_r + 8'h01;
					end else if (done) begin
						state_r <= ST_IDLE;
						own_r <= OWN_CPU;
					end else if (yield_now) begin
						state_r <= ST_YIELD;
						own_r <= refresh_req ? OWN_REF : OWN_HOLD;
					end else if (steal) begin
						if (ai.hit) begin
							act_r <= ai.win;
							cyc_r <= 8'h00;
						end else begin
							state_r <= ST_IDLE;
							own_r <= OWN_CPU;
						end
					end else if (!flag_r[act_r]) begin
						state_r <= ST_IDLE;
						own_r <= OWN_CPU;
					end else begin
						cyc_r <= 8'h00;
					end
				end
				ST_YIELD: begin
					if (force_end) begin
						state_r <= ST_IDLE;
						own_r <= OWN_CPU;
					end else if (!yield_now) begin
						state_r <= ST_XFER;
						own_r <= OWN_DMA;
						cyc_r <= 8'h00;
					end else begin
						own_r <= refresh_req ? OWN_REF : OWN_HOLD;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					own_r <= OWN_CPU;
				end
			endcase
		end
	end

	// unit and completion pulses
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			unit_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			unit_r <= unit_end && !force_end;
			done_r <= done;
		end
	end

	// register read port
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			rdata_r <= 16'h0000;
			case (blk_sel)
				A_GXC[7:2]: begin
					if (reg_addr == A_GXC) begin
						rdata_r <= {8'h00, perm_r, 3'b000, rot_r};
					end else if (reg_addr == A_STAT) begin
						rdata_r <= {8'h00, ai.top, state_r, act_r, own_r};
					end
				end
				A_CTRL[7:2]: begin
					rdata_r <= {ctrl_r[ridx][15:6], flag_r[ridx], ctrl_r[ridx][4:0]};
				end
				A_MODE[7:2]: begin
					rdata_r <= mode_r[ridx];
				end
				A_CNT[7:2]: begin
					rdata_r <= cnt_r[ridx];
				end
				A_BLK[7:2]: begin
					rdata_r <= {8'h00, blk_r[ridx]};
				end
				default: begin
					rdata_r <= 16'h0000;
				end
			endcase
		end
	end

	assign reg_rdata = rdata_r;
	assign bus_owner = own_r;
	assign xfer_ch = act_r;
	assign unit_pulse = unit_r;
	assign xfer_done = done_r;

	// checks
	property p_edge_rst;
		@(posedge clock) $fell(sys_rst) |-> !ctrl_r[0][B_LVL] && !rot_r;
	endproperty
	a_edge_rst: assert property (p_edge_rst) else $error("reset not edge and fixed");
	property p_edge_set;
		@(posedge clock) disable iff (sys_rst)
		(!lvl[0] && ctrl_r[0][3:0] == SRC_EXT && pin_fall[0]) |=> flag_r[0];
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("falling pin lost");
	property p_term_clr;
		@(posedge clock) disable iff (sys_rst)
		(state_r == ST_XFER && term_low && !lvl[act_r] && !set_v[act_r])
		|=> !flag_r[$past(act_r)] && state_r == ST_IDLE;
	endproperty
	a_term_clr: assert property (p_term_clr) else $error("terminal pin did not stop");
	property p_ref_first;
		@(posedge clock) disable iff (sys_rst)
		(state_r == ST_IDLE && refresh_req) |=> own_r == OWN_REF;
	endproperty
	a_ref_first: assert property (p_ref_first) else $error("refresh not granted");
	property p_resume;
		@(posedge clock) disable iff (sys_rst)
		(state_r == ST_YIELD && !yield_now && !force_end)
		|=> state_r == ST_XFER && $stable(act_r) && $stable(cnt_r[act_r]);
	endproperty
	a_resume: assert property (p_resume) else $error("resume lost its place");
	property p_burst_lock;
		@(posedge clock) disable iff (sys_rst)
		(state_r == ST_XFER && !steal) |=> $stable(act_r);
	endproperty
	a_burst_lock: assert property (p_burst_lock) else $error("burst switched channel");
	property p_done_cpu;
		@(posedge clock) disable iff (sys_rst)
		done |=> own_r == OWN_CPU && xfer_done && !perm_r[$past(act_r)];
	endproperty
	a_done_cpu: assert property (p_done_cpu) else $error("end did not release");
	property p_level;
		@(posedge clock) disable iff (sys_rst)
		(|lvl) |=> (flag_r & $past(lvl)) == ($past(pin_low[3:0]) & $past(lvl));
	endproperty
	a_level: assert property (p_level) else $error("level flag off pin");
	property p_pause;
		@(posedge clock) disable iff (sys_rst)
		(unit_end && !force_end && !done && !yield_now && !steal && !flag_r[act_r])
		|=> state_r == ST_IDLE && perm_r[$past(act_r)];
	endproperty
	a_pause: assert property (p_pause) else $error("pause dropped permit");
	property p_cs_clr;
		@(posedge clock) disable iff (sys_rst)
		(cs_next && !set_v[ai.win] && !lvl[ai.win]) |=> !flag_r[$past(ai.win)];
	endproperty
	a_cs_clr: assert property (p_cs_clr) else $error("steal flag kept");
	property p_accept;
		@(posedge clock) disable iff (sys_rst)
		accept |-> perm_r[ai.win] && flag_r[ai.win];
	endproperty
	a_accept: assert property (p_accept) else $error("accepted without permit");
	property p_force_keep;
		@(posedge clock) disable iff (sys_rst)
		(force_end && !wr_gxc) |=> $stable(ai.top);
	endproperty
	a_force_keep: assert property (p_force_keep) else $error("forced end rotated");
	c_burst: cover property (@(posedge clock) disable iff (sys_rst) done && !steal);
	c_steal: cover property (@(posedge clock) disable iff (sys_rst) cs_next);
	c_yield: cover property (@(posedge clock) disable iff (sys_rst) state_r == ST_YIELD);
	c_rotate: cover property (@(posedge clock) disable iff (sys_rst) done && rot_r);
endmodule : drq_core

// [core/drq_pin_sync.sv]
// two-stage pin synchronisers with falling edge detect
`timescale 1ns/1ps
module drq_pin_sync
	import drq_pkg::*;
#(
	parameter int W = 5
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin_n,
	output logic [W-1:0] low,
	output logic [W-1:0] fall
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	for (genvar g = 0; g < W; g++) begin : g_pin
		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				s1_r[g] <= 1'b1;
				s2_r[g] <= 1'b1;
				s3_r[g] <= 1'b1;
			end else begin
				s1_r[g] <= pin_n[g];
				s2_r[g] <= s1_r[g];
				s3_r[g] <= s2_r[g];
			end
		end
		assign low[g] = ~s2_r[g];
		assign fall[g] = s3_r[g] & ~s2_r[g];
	end
	property p_fall_once;
		@(posedge clock) disable iff (sys_rst) fall[0] |=> !fall[0];
	endproperty
	a_fall_once: assert property (p_fall_once) else $error("edge pulse longer than one cycle");
endmodule : drq_pin_sync

// [core/drq_pkg.sv]
// shared constants and types for the request sense and priority block
package drq_pkg;
	localparam int NCH = 4;
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int NPER = 13;
	localparam int UNIT_CYC_DEF = 4;
	localparam logic [7:0] A_GXC = 8'h00;
	localparam logic [7:0] A_STAT = 8'h01;
	localparam logic [7:0] A_CTRL = 8'h08;
	localparam logic [7:0] A_MODE = 8'h0C;
	localparam logic [7:0] A_CNT = 8'h10;
	localparam logic [7:0] A_BLK = 8'h14;
	localparam int B_ROT = 0;
	localparam int B_PERM = 4;
	localparam int B_SWRQ = 8;
	localparam int B_LVL = 4;
	localparam int B_FLAG = 5;
	localparam int B_STEAL = 2;
	localparam int B_CHAIN = 8;
	localparam logic [3:0] SRC_EXT = 4'h1;
	localparam logic [3:0] SRC_SW = 4'h2;
	localparam logic [3:0] SRC_PER = 4'h3;
	localparam logic [15:0] RST_GXC = 16'h0000;
	localparam logic [15:0] RST_CTRL = 16'h0000;
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [15:0] RST_CNT = 16'h0000;
	localparam logic [7:0] RST_BLK = 8'h00;
	typedef enum logic [1:0] {
		OWN_CPU = 2'b00,
		OWN_DMA = 2'b01,
		OWN_REF = 2'b10,
		OWN_HOLD = 2'b11
	} drq_own_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_XFER = 2'b01,
		ST_YIELD = 2'b10
	} drq_st_t;
endpackage : drq_pkg

// [core/drq_prio.sv]
// fixed or rotating channel priority picker
`timescale 1ns/1ps
module drq_prio
	import drq_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	drq_arb_if.arb ai
);
	logic [1:0] top_r;
	logic [1:0] idx;
	assign ai.top = top_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			top_r <= 2'b00;
		end else if (!ai.rot_en) begin
			top_r <= 2'b00;
		end else if (ai.done) begin
			top_r <= 2'(ai.done_ch + 2'b01);
		end
	end
	always_comb begin
		idx = 2'b00;
		ai.hit = 1'b0;
		ai.win = 2'b00;
		for (int k = NCH - 1; k >= 0; k--) begin
			idx = 2'(top_r + 2'(k));
			if (ai.pend[idx]) begin
				ai.hit = 1'b1;
				ai.win = idx;
			end
		end
	end
	property p_fixed_order;
		@(posedge clock) disable iff (sys_rst)
		(top_r == 2'b00 && ai.pend[0]) |-> ai.win == 2'b00;
	endproperty
	a_fixed_order: assert property (p_fixed_order) else $error("channel 0 not first");
	property p_rotate;
		@(posedge clock) disable iff (sys_rst)
		(ai.done && ai.rot_en) |=> top_r == 2'($past(ai.done_ch) + 2'b01);
	endproperty
	a_rotate: assert property (p_rotate) else $error("finished channel not made lowest");
endmodule : drq_prio

// [tb/drq_pin_model.sv]
// peripheral side model: request pin pulses and levels, terminal pin pulse
`timescale 1ns/1ps
module drq_pin_model
	import drq_pkg::*;
(
	input wire logic clock,
	input wire logic [NCH-1:0] pulse,
	input wire logic [NCH-1:0] hold_low,
	input wire logic tc_pulse,
	output logic [NCH-1:0] ext_xfer_request_n,
	output logic terminal_count_n
);
	logic [NCH-1:0][1:0] cnt_r = '0;
	logic [1:0] tc_cnt_r = 2'h0;
	// each pulse holds the pin low for three clocks, long enough to pass two flops
	always_ff @(posedge clock) begin
		for (int i = 0; i < NCH; i++) begin
			if (pulse[i]) begin
				cnt_r[i] <= 2'h3;
			end else if (cnt_r[i] != 2'h0) begin
				cnt_r[i] <= cnt_r[i] - 2'h1;
			end
		end
		if (tc_pulse) begin
			tc_cnt_r <= 2'h3;
		end else if (tc_cnt_r != 2'h0) begin
			tc_cnt_r <= tc_cnt_r - 2'h1;
		end
	end
	// released pins go back high through the pull-up
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ext_xfer_request_n[i] = !(cnt_r[i] != 2'h0 || hold_low[i]);
		end
		terminal_count_n = (tc_cnt_r == 2'h0);
	end
endmodule : drq_pin_model

// [tb/tb.sv]
// self-checking bench for the request sense and priority block
`timescale 1ns/1ps
module tb;
	import drq_pkg::*;
	localparam int UC = 2;
	typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} drq_row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [AW-1:0] reg_addr = '0;
	logic [DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DW-1:0] reg_rdata;
	logic [NCH-1:0] ext_xfer_request_n;
	logic terminal_count_n;
	logic refresh_req = 1'b0;
	logic hold_req = 1'b0;
	logic [NPER-1:0] periph_evt = '0;
	drq_own_t bus_owner;
	logic [1:0] xfer_ch;
	logic unit_pulse;
	logic xfer_done;
	logic [NCH-1:0] pulse = '0;
	logic [NCH-1:0] hold_low = '0;
	logic tc_pulse = 1'b0;
	int num_errors = 0;
	int check_count = 0;
	int units = 0;
	int dones = 0;
	int u;
	logic [DW-1:0] rv;
	drq_row_t rows [8] = '{
		'{A_GXC, 16'h0F01, 16'h0001}, '{A_CTRL, 16'hFF32, 16'hFF12},
		'{A_CTRL + 8'h03, 16'h0011, 16'h0011}, '{A_MODE + 8'h01, 16'h0104, 16'h0104},
		'{A_CNT + 8'h02, 16'h1234, 16'h1234}, '{A_BLK, 16'h00AB, 16'h00AB},
		'{A_STAT, 16'hFFFF, 16'h0000}, '{8'h20, 16'hFFFF, 16'h0000}};
	always #50 clock = ~clock;
	drq_core #(.UNIT_CYC(UC)) drq_core_i (.clock(clock), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_xfer_request_n(ext_xfer_request_n),
		.terminal_count_n(terminal_count_n), .periph_evt(periph_evt),
		.refresh_req(refresh_req),
		.hold_req(hold_req), .bus_owner(bus_owner), .xfer_ch(xfer_ch),
		.unit_pulse(unit_pulse), .xfer_done(xfer_done));
	drq_pin_model drq_pin_model_i (.clock(clock), .pulse(pulse), .hold_low(hold_low),
		.tc_pulse(tc_pulse), .ext_xfer_request_n(ext_xfer_request_n),
		.terminal_count_n(terminal_count_n));
	always @(negedge clock) begin
		if (unit_pulse === 1'b1) units++;
		if (xfer_done === 1'b1) dones++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask : rd
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rdchk
	task automatic pin(input logic [NCH-1:0] m);
		@(posedge clock);
		pulse <= m;
		@(posedge clock);
		pulse <= '0;
	endtask : pin
	task automatic wait_own(input drq_own_t o);
		int n;
		n = 0;
		while (bus_owner !== o && n < 300) begin
			@(negedge clock);
			#1;
			n++;
		end
		chk({14'h0, bus_owner}, {14'h0, o});
	endtask : wait_own
	task automatic wait_done;
		int n;
		int d0;
		n = 0;
		d0 = dones;
		while (dones == d0 && n < 300) begin
			@(negedge clock);
			#1;
			n++;
		end
		chk(16'(dones - d0), 16'h0001);
	endtask : wait_done
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rdchk(rows[i].a, rows[i].e);
		end
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rdchk(A_GXC, RST_GXC);
		rdchk(A_CTRL, RST_CTRL);
		rdchk(A_MODE + 8'h01, RST_MODE);
		wr(A_CTRL, 16'h0001);
		wr(A_CNT, 16'h0002);
		pin(4'h1);
		repeat (8) @(negedge clock);
		chk({14'h0, bus_owner}, 16'h0000);
		rdchk(A_CTRL, 16'h0021);
		wr(A_GXC, 16'h0010);
		wait_own(OWN_DMA);
		u = units;
		wait_done();
		chk(16'(units - u), 16'h0002);
		chk({14'h0, bus_owner}, 16'h0000);
		rdchk(A_GXC, 16'h0000);
		rdchk(A_CTRL, 16'h0001);
		wr(A_CNT, 16'h0003);
		wr(A_GXC, 16'h0010);
		pin(4'h1);
		wait_own(OWN_DMA);
		u = units;
		@(posedge clock);
		refresh_req <= 1'b1;
		hold_req <= 1'b1;
		wait_own(OWN_REF);
		@(posedge clock);
		refresh_req <= 1'b0;
		wait_own(OWN_HOLD);
		@(posedge clock);
		hold_req <= 1'b0;
		wait_done();
		chk(16'(units - u), 16'h0003);
		wr(A_CTRL + 8'h01, 16'h0001);
		wr(A_CNT + 8'h01, 16'h0006);
		wr(A_CTRL, 16'h0002);
		wr(A_CNT, 16'h0001);
		wr(A_GXC, 16'h0020);
		pin(4'h2);
		wait_own(OWN_DMA);
		chk({14'h0, xfer_ch}, 16'h0001);
		wr(A_GXC, 16'h0130);
		repeat (3) @(negedge clock);
		chk({14'h0, xfer_ch}, 16'h0001);
		wait_done();
		wait_own(OWN_DMA);
		chk({14'h0, xfer_ch}, 16'h0000);
		wait_done();
		wr(A_CNT, 16'h0001);
		wr(A_GXC, 16'h0111);
		wait_done();
		rd(A_STAT, rv);
		chk({14'h0, rv[7:6]}, 16'h0001);
		wr(A_CNT + 8'h01, 16'h0008);
		wr(A_GXC, 16'h0021);
		pin(4'h2);
		wait_own(OWN_DMA);
		u = dones;
		@(posedge clock);
		tc_pulse <= 1'b1;
		@(posedge clock);
		tc_pulse <= 1'b0;
		wait_own(OWN_CPU);
		chk(16'(dones - u), 16'h0000);
		rd(A_STAT, rv);
		chk({14'h0, rv[7:6]}, 16'h0001);
		rdchk(A_CTRL + 8'h01, 16'h0001);
		wr(A_GXC, 16'h0000);
		wr(A_CTRL + 8'h02, 16'h0011);
		wr(A_CNT + 8'h02, 16'h0004);
		@(posedge clock);
		hold_low <= 4'h4;
		wr(A_GXC, 16'h0040);
		wait_own(OWN_DMA);
		u = units;
		@(posedge clock);
		hold_low <= 4'h0;
		wait_own(OWN_CPU);
		rdchk(A_GXC, 16'h0040);
		rdchk(A_CTRL + 8'h02, 16'h0011);
		@(posedge clock);
		hold_low <= 4'h4;
		wait_done();
		chk(16'(units - u), 16'h0004);
		rdchk(A_GXC, 16'h0000);
		rdchk(A_CTRL + 8'h02, 16'h0031);
		@(posedge clock);
		hold_low <= 4'h0;
		wr(A_MODE, 16'h0004);
		wr(A_MODE + 8'h01, 16'h0004);
		wr(A_CTRL + 8'h01, 16'h0002);
		wr(A_CNT, 16'h0003);
		wr(A_CNT + 8'h01, 16'h0003);
		wr(A_GXC, 16'h0330);
		wait_own(OWN_DMA);
		chk({14'h0, xfer_ch}, 16'h0000);
		u = units;
		wait_own(OWN_CPU);
		chk(16'(units - u), 16'h0002);
		rdchk(A_GXC, 16'h0030);
		rdchk(A_CTRL, 16'h0002);
		wr(A_CTRL + 8'h03, 16'h0003);
		wr(A_CNT + 8'h03, 16'h0001);
		wr(A_GXC, 16'h0080);
		@(posedge clock);
		periph_evt <= 13'h0001;
		@(posedge clock);
		periph_evt <= '0;
		wait_done();
		chk({14'h0, xfer_ch}, 16'h0003);
		chk({14'h0, bus_owner}, 16'h0000);
		end_sim();
	end
endmodule : tb
